// >>> limk_core.sv
// interrupt event and mask registers with external interrupt line
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module limk_core
    import limk_pkg::*;
(
    input wire logic sys_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire limk_src_t evt_src, // event source levels
    input wire logic [7:0] iso_rx_ctx_irq, // per iso-rx context request
    input wire logic [7:0] iso_tx_ctx_irq, // per iso-tx context request
    output logic irq_out // external interrupt, active high
);
    limk_state_t s_r, s_nxt;
    logic [31:0] be_mask, wbits, evt_view, src_edge32;
    logic [LIMK_N_SRC-1:0] src_edge;
    logic hit;

    // map compact source vector onto event positions
    localparam int SRC_POS [LIMK_N_SRC] = '{30, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};

    always_comb begin
        be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wbits = avs_writedata & be_mask;
        src_edge = s_r.src_s2 & ~s_r.src_prev;
        src_edge32 = '0;
        for (int i = 0; i < LIMK_N_SRC; i++) begin
            src_edge32[SRC_POS[i]] = src_edge[LIMK_N_SRC-1-i];
        end
        // summary bits are computed, never stored
        evt_view = s_r.evt & LIMK_EVT_LATCH_MASK;
        evt_view[LIMK_BIT_ISO_RX] = |(s_r.iso_rx_evt & s_r.iso_rx_msk);
        evt_view[LIMK_BIT_ISO_TX] = |(s_r.iso_tx_evt & s_r.iso_tx_msk);
    end

    always_comb begin
        s_nxt = s_r;
        hit = (avs_read || avs_write) && s_r.wait_n;
        s_nxt.src_s1 = evt_src;
        s_nxt.src_s2 = s_r.src_s1;
        s_nxt.src_prev = s_r.src_s2;
        s_nxt.iso_rx_s1 = iso_rx_ctx_irq;
        s_nxt.iso_rx_s2 = s_r.iso_rx_s1;
        s_nxt.iso_rx_prev = s_r.iso_rx_s2;
        s_nxt.iso_tx_s1 = iso_tx_ctx_irq;
        s_nxt.iso_tx_s2 = s_r.iso_tx_s1;
        s_nxt.iso_tx_prev = s_r.iso_tx_s2;
        // one wait cycle per access: request taken on the second edge
        s_nxt.wait_n = (avs_read || avs_write) && !s_r.wait_n;
        if (hit && avs_write) begin
            unique case (avs_address)
                LIMK_OFF_EVT_SET: s_nxt.evt = s_r.evt | (wbits & LIMK_EVT_LATCH_MASK);
                LIMK_OFF_EVT_CLR: s_nxt.evt = s_r.evt & ~(wbits & LIMK_EVT_LATCH_MASK);
                LIMK_OFF_MSK_SET: s_nxt.msk = s_r.msk | (wbits & LIMK_MSK_WR_MASK);
                LIMK_OFF_MSK_CLR: s_nxt.msk = s_r.msk & ~(wbits & LIMK_MSK_WR_MASK);
                LIMK_OFF_ISO_RX_EVT: s_nxt.iso_rx_evt = s_r.iso_rx_evt & ~wbits[7:0];
                LIMK_OFF_ISO_RX_MSK: s_nxt.iso_rx_msk = wbits[7:0] | (s_r.iso_rx_msk & ~be_mask[7:0]);
                LIMK_OFF_ISO_TX_EVT: s_nxt.iso_tx_evt = s_r.iso_tx_evt & ~wbits[7:0];
                LIMK_OFF_ISO_TX_MSK: s_nxt.iso_tx_msk = wbits[7:0] | (s_r.iso_tx_msk & ~be_mask[7:0]);
                default: ;
            endcase
        end
        // hardware edges win over a same-cycle clear
        s_nxt.evt = s_nxt.evt | src_edge32;
        if (src_edge32[LIMK_BIT_BUS_RESET]) begin
            s_nxt.evt[LIMK_BIT_SELF_ID] = 1'b0;
        end
        s_nxt.iso_rx_evt = s_nxt.iso_rx_evt | (s_r.iso_rx_s2 & ~s_r.iso_rx_prev);
        s_nxt.iso_tx_evt = s_nxt.iso_tx_evt | (s_r.iso_tx_s2 & ~s_r.iso_tx_prev);
        s_nxt.rdata = LIMK_UNMAPPED_VAL;
        // latched on the edge that first sees the read, so the data stand
        // at the edge where the master samples waitrequest low
        if (avs_read && !s_r.wait_n) begin
            unique case (avs_address)
                LIMK_OFF_EVT_SET: s_nxt.rdata = evt_view;
                LIMK_OFF_EVT_CLR: s_nxt.rdata = evt_view & s_r.msk;
                LIMK_OFF_MSK_SET, LIMK_OFF_MSK_CLR: s_nxt.rdata = s_r.msk;
                LIMK_OFF_ISO_RX_EVT: s_nxt.rdata = {24'h000000, s_r.iso_rx_evt};
                LIMK_OFF_ISO_RX_MSK: s_nxt.rdata = {24'h000000, s_r.iso_rx_msk};
                LIMK_OFF_ISO_TX_EVT: s_nxt.rdata = {24'h000000, s_r.iso_tx_evt};
                LIMK_OFF_ISO_TX_MSK: s_nxt.rdata = {24'h000000, s_r.iso_tx_msk};
                default: s_nxt.rdata = LIMK_UNMAPPED_VAL;
            endcase
        end
        // mask bits 30..0 gate events one for one; 31 is the gate of all
        s_nxt.irq = s_r.msk[LIMK_BIT_GLOBAL_EN] &&
                    (|(evt_view[30:0] & s_r.msk[30:0]));
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = !s_r.wait_n;
    assign irq_out = s_r.irq;

    chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !s_r.msk[LIMK_BIT_GLOBAL_EN] |=> !irq_out) else $error("irq while globally disabled");
    chk_irq_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        irq_out == $past(s_r.msk[31] && |(evt_view[30:0] & s_r.msk[30:0]))) else $error("irq mismatch");
    chk_bus_reset_entered_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-2] |=> s_r.evt[LIMK_BIT_BUS_RESET]) else $error("bus reset not latched");
    chk_selfid_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-2] |=> !s_r.evt[LIMK_BIT_SELF_ID]) else $error("self id not cleared");
    chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        evt_view[15:10] == 6'h00) else $error("reserved bits nonzero");
    chk_lock_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-4] |=> s_r.evt[9]) else $error("lock error not latched");
    chk_posted_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-5] |=> s_r.evt[8]) else $error("posted error not latched");
    chk_tx_done: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[0] |=> s_r.evt[0]) else $error("tx request done not latched");
    chk_mask_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
        avs_read && !s_r.wait_n && avs_address == LIMK_OFF_MSK_CLR |=> avs_readdata == $past(s_r.msk))
        else $error("mask read mismatch");
    chk_iso_rx_sum: assert property (@(posedge sys_clk) disable iff (!arst_n)
        evt_view[7] == |(s_r.iso_rx_evt & s_r.iso_rx_msk)) else $error("iso rx summary wrong");
    chk_clr_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_r.evt[0] && !(hit && avs_write && avs_address == LIMK_OFF_EVT_CLR) |=> s_r.evt[0])
        else $error("event lost without clear");
    cov_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(irq_out));
    cov_bus_reset_entered: cover property (@(posedge sys_clk) disable iff (!arst_n) src_edge[LIMK_N_SRC-2]);
    cov_clr_write: cover property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && avs_address == LIMK_OFF_EVT_CLR);
    cov_selfid_cleared: cover property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-2] && s_r.evt[LIMK_BIT_SELF_ID]);
    cov_iso_summary: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(evt_view[LIMK_BIT_ISO_RX]));

    // remaining source edges: each must land in its own event bit one edge later, self ID only without a same-cycle bus reset edge

    chk_selfid_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-3] && !src_edge[LIMK_N_SRC-2] |=> s_r.evt[LIMK_BIT_SELF_ID])
        else $error("self id not latched");

    chk_resp_pkt: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[5] |=> s_r.evt[5])
        else $error("response packet not latched");

    chk_req_pkt: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[4] |=> s_r.evt[4])
        else $error("request packet not latched");

    chk_rx_resp_ctx: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[3] |=> s_r.evt[3])
        else $error("rx response context not latched");

    chk_rx_req_ctx: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[2] |=> s_r.evt[2])
        else $error("rx request context not latched");

    chk_tx_resp_done: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[1] |=> s_r.evt[1])
        else $error("tx response done not latched");

    chk_vendor_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        src_edge[LIMK_N_SRC-1] |=> s_r.evt[LIMK_BIT_VENDOR])
        else $error("vendor event not latched");

    // summary and reserved positions

    chk_iso_tx_sum: assert property (@(posedge sys_clk) disable iff (!arst_n)
        evt_view[LIMK_BIT_ISO_TX] == |(s_r.iso_tx_evt & s_r.iso_tx_msk))
        else $error("iso tx summary wrong");

    chk_evt_rsvd: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (s_r.evt & ~LIMK_EVT_LATCH_MASK) == 32'h0000_0000)
        else $error("event reserved bit stored");

    chk_mask_rsvd: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (s_r.msk & ~LIMK_MSK_WR_MASK) == 32'h0000_0000)
        else $error("mask reserved bit stored");

    // register reads: data latched when the request is first seen

    chk_mask_read_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        avs_read && !s_r.wait_n && avs_address == LIMK_OFF_MSK_SET |=> avs_readdata == $past(s_r.msk))
        else $error("mask set read mismatch");

    chk_evt_read_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
        avs_read && !s_r.wait_n && avs_address == LIMK_OFF_EVT_SET |=> avs_readdata == $past(evt_view))
        else $error("event read mismatch");

    chk_evt_read_clr: assert property (@(posedge sys_clk) disable iff (!arst_n)
        avs_read && !s_r.wait_n && avs_address == LIMK_OFF_EVT_CLR |=>
        avs_readdata == $past(evt_view & s_r.msk))
        else $error("event and mask read mismatch");

    // register writes: set, clear and untouched zero positions

    chk_evt_set_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && avs_address == LIMK_OFF_EVT_SET && !src_edge[LIMK_N_SRC-2] |=>
        (s_r.evt & $past(wbits & LIMK_EVT_LATCH_MASK)) == $past(wbits & LIMK_EVT_LATCH_MASK))
        else $error("event set write lost");

    chk_evt_clr_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && avs_address == LIMK_OFF_EVT_CLR && src_edge == '0 |=>
        (s_r.evt & $past(wbits & LIMK_EVT_LATCH_MASK)) == 32'h0000_0000)
        else $error("event clear write lost");

    chk_msk_set_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && avs_address == LIMK_OFF_MSK_SET |=>
        (s_r.msk & $past(wbits & LIMK_MSK_WR_MASK)) == $past(wbits & LIMK_MSK_WR_MASK))
        else $error("mask set write lost");

    chk_msk_clr_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && avs_address == LIMK_OFF_MSK_CLR |=>
        (s_r.msk & $past(wbits & LIMK_MSK_WR_MASK)) == 32'h0000_0000)
        else $error("mask clear write lost");

    chk_msk_zero_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hit && avs_write && (avs_address == LIMK_OFF_MSK_SET || avs_address == LIMK_OFF_MSK_CLR) |=>
        (s_r.msk & ~$past(wbits)) == ($past(s_r.msk) & ~$past(wbits)))
        else $error("mask zero bit changed");

    chk_msk_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(hit && avs_write && (avs_address == LIMK_OFF_MSK_SET || avs_address == LIMK_OFF_MSK_CLR)) |=>
        $stable(s_r.msk))
        else $error("mask changed without write");

    // interrupt gating by individual enables

    chk_irq_masked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_r.msk[LIMK_BIT_GLOBAL_EN] && (evt_view[30:0] & s_r.msk[30:0]) == 31'h0000_0000 |=> !irq_out)
        else $error("irq with no enabled event");

    chk_vendor_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !s_r.msk[LIMK_BIT_VENDOR] && (evt_view[29:0] & s_r.msk[29:0]) == 30'h0000_0000 |=> !irq_out)
        else $error("vendor event not gated");

    // bus handshake: exactly one wait state, data only while waitrequest is low

    chk_wait_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held too long");

    chk_wait_back: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");

    chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data outside answer");

    // per-context latching of the iso event bits behind the summaries
    generate
        for (genvar c = 0; c < 8; c++) begin : g_iso_chk
            chk_iso_rx_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
                s_r.iso_rx_s2[c] && !s_r.iso_rx_prev[c] |=> s_r.iso_rx_evt[c])
                else $error("iso rx context not latched");
            chk_iso_tx_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
                s_r.iso_tx_s2[c] && !s_r.iso_tx_prev[c] |=> s_r.iso_tx_evt[c])
                else $error("iso tx context not latched");
        end
    endgenerate
endmodule // limk_core

`default_nettype wire

// >>> limk_pkg.sv
// package for the link interrupt event and mask block
package limk_pkg;
    localparam logic [7:0] LIMK_OFF_EVT_SET = 8'h80;
    localparam logic [7:0] LIMK_OFF_EVT_CLR = 8'h84;
    localparam logic [7:0] LIMK_OFF_MSK_SET = 8'h88;
    localparam logic [7:0] LIMK_OFF_MSK_CLR = 8'h8c;
    localparam logic [7:0] LIMK_OFF_ISO_RX_EVT = 8'ha0;
    localparam logic [7:0] LIMK_OFF_ISO_RX_MSK = 8'ha4;
    localparam logic [7:0] LIMK_OFF_ISO_TX_EVT = 8'ha8;
    localparam logic [7:0] LIMK_OFF_ISO_TX_MSK = 8'hac;
    localparam int LIMK_BIT_BUS_RESET = 17;
    localparam int LIMK_BIT_SELF_ID = 16;
    localparam int LIMK_BIT_ISO_RX = 7;
    localparam int LIMK_BIT_ISO_TX = 6;
    localparam int LIMK_BIT_GLOBAL_EN = 31;
    localparam int LIMK_BIT_VENDOR = 30;
    // latched event positions: 30, 17, 16, 9, 8, 5..0
    localparam logic [31:0] LIMK_EVT_LATCH_MASK = 32'h4003_033f;
    // mask positions: 31, 30, 17, 16, 9..0 (iso summary enables included)
    localparam logic [31:0] LIMK_MSK_WR_MASK = 32'hc003_03ff;
    localparam logic [31:0] LIMK_RST_VAL = 32'h0000_0000;
    localparam logic [31:0] LIMK_UNMAPPED_VAL = 32'h0000_0000;
    localparam int LIMK_N_SRC = 11;

    // event source inputs, in the order 30,17,16,9,8,5,4,3,2,1,0
    typedef struct packed {
        logic vendor_event;
        logic bus_reset_entered;
        logic self_identification_done;
        logic lock_response_error;
        logic posted_write_error;
        logic response_packet_received;
        logic request_packet_received;
        logic async_rx_response_context;
        logic async_rx_request_context;
        logic response_transmit_done;
        logic request_transmit_done;
    } limk_src_t;

    typedef struct packed {
        logic [31:0] evt;
        logic [31:0] msk;
        logic [7:0] iso_rx_evt;
        logic [7:0] iso_rx_msk;
        logic [7:0] iso_tx_evt;
        logic [7:0] iso_tx_msk;
        logic [LIMK_N_SRC-1:0] src_prev;
        logic [LIMK_N_SRC-1:0] src_s1;
        logic [LIMK_N_SRC-1:0] src_s2;
        logic [7:0] iso_rx_s1;
        logic [7:0] iso_rx_s2;
        logic [7:0] iso_rx_prev;
        logic [7:0] iso_tx_s1;
        logic [7:0] iso_tx_s2;
        logic [7:0] iso_tx_prev;
        logic wait_n;
        logic [31:0] rdata;
        logic irq;
    } limk_state_t;
endpackage

// >>> limk_tb.sv
// self-checking bench for the link interrupt event and mask block
`timescale 1ns/1ns
`default_nettype none
module link_interrupt_event_mask_tb;
    import limk_pkg::*;
    logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq_out;
    logic [7:0] avs_address, iso_rx, iso_tx;
    logic [31:0] avs_writedata, avs_readdata, q, d, em, mm;
    logic [3:0] avs_byteenable, be;
    limk_src_t evt_src;
    int err_count, tests_run, seed, i;
    int pos[11] = '{30, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
    logic [7:0] adr[5] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h40};
    limk_core limk_core_i (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt_src(evt_src),
        .iso_rx_ctx_irq(iso_rx), .iso_tx_ctx_irq(iso_tx), .irq_out(irq_out));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // values read right after the edge are those the edge sampled; data taken at the edge waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) err_count++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    // sources are synchronised inside, so a pulse must last a few cycles
    task automatic pulse(input int b);
        evt_src[b] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        evt_src <= '0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic irq_chk(input logic e);
        repeat (6) @(posedge sys_clk);
        chk("irq_out", {31'h0, e}, {31'h0, irq_out});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        seed = 8663;
        {arst_n, avs_read, avs_write, avs_address, avs_writedata, iso_rx, iso_tx, em} = '0;
        avs_byteenable = 4'hf;
        evt_src = '0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 5; i++) rd(adr[i], LIMK_RST_VAL, "reset_value");
        $display("test reset done");
        for (i = 0; i < 11; i++) begin
            pulse(10 - i);
            em[pos[i]] = 1'b1;
            if (pos[i] == 17) em[16] = 1'b0;
            rd(8'h80, em, "event_source");
        end
        pulse(9);
        em[16] = 1'b0;
        rd(8'h80, em, "bus_reset_clears_self_id");
        bus(1'b1, 8'h84, 32'h0000_0001);
        em[0] = 1'b0;
        rd(8'h80, em, "event_clear_one");
        $display("test event sources done");
        repeat (4) begin
            d = $random(seed);
            be = 4'($random(seed));
            bus(1'b1, 8'h8c, 32'hffff_ffff);
            avs_byteenable <= be;
            bus(1'b1, 8'h88, d);
            avs_byteenable <= 4'hf;
            mm = d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & LIMK_MSK_WR_MASK;
            rd(8'h88, mm, "mask_set_read");
            rd(8'h8c, mm, "mask_clear_read");
            rd(8'h84, em & mm, "event_and_mask");
        end
        bus(1'b1, 8'h80, 32'hffff_ffff);
        em = LIMK_EVT_LATCH_MASK;
        rd(8'h80, em, "event_set_all");
        $display("test mask and reserved done");
        bus(1'b1, 8'h8c, 32'hffff_ffff);
        bus(1'b1, 8'h88, 32'h8000_0000);
        irq_chk(1'b0);
        bus(1'b1, 8'h88, 32'h4000_0000);
        irq_chk(1'b1);
        bus(1'b1, 8'h8c, 32'h8000_0000);
        irq_chk(1'b0);
        bus(1'b1, 8'h88, 32'h8000_0000);
        bus(1'b1, 8'h84, 32'h4000_0000);
        irq_chk(1'b0);
        bus(1'b1, 8'h88, 32'h0000_0001);
        irq_chk(1'b1);
        $display("test interrupt line done");
        bus(1'b1, 8'h84, 32'hffff_ffff);
        bus(1'b1, 8'h8c, 32'hffff_ffff);
        bus(1'b1, 8'ha4, 32'h0000_0001);
        iso_rx <= 8'h01;
        iso_tx <= 8'h04;
        repeat (8) @(posedge sys_clk);
        rd(8'h80, 32'h0000_0080, "iso_rx_summary");
        bus(1'b1, 8'hac, 32'h0000_0004);
        rd(8'h80, 32'h0000_00c0, "iso_tx_summary");
        bus(1'b1, 8'h88, 32'h8000_0080);
        irq_chk(1'b1);
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rd(8'h40, LIMK_UNMAPPED_VAL, "unmapped");
        $display("test iso summary done");
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
endmodule // link_interrupt_event_mask_tb
`default_nettype wire
